// ===== dv/sbxfer_mc.sv
// management controller model that issues sideband commands and chunk words
`default_nettype none
module sbxfer_mc (
    input wire logic clk_i, // clock
    output logic valid_o, // command strobe
    output logic [7:0] type_o, // command code
    output logic [4:0] chan_o, // internal channel id
    output logic [1:0] hdr_err_o, // checksum and identifier errors
    output logic [31:0] w16_o, // bytes 16..19
    output logic [31:0] w20_o, // bytes 20..23
    output logic [31:0] w24_o, // bytes 24..27
    output logic err_o, // current chunk corrupted
    output logic dv_o, // chunk word strobe
    output logic [31:0] data_o // chunk word
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {valid_o, type_o, chan_o, hdr_err_o, w16_o, w20_o, w24_o, err_o, dv_o, data_o} = '0;
    end
    // released fields except w20_o show inverted values so stale data cannot pass for fresh; w20_o stays zero
    task automatic cmd(input logic [7:0] t, input logic [4:0] c, input logic [31:0] op, input logic [31:0] num,
                       input logic [1:0] he, input logic e);
        @(posedge clk_i);
        {valid_o, type_o, chan_o, hdr_err_o, w16_o, w24_o, err_o} <= {1'b1, t, c, he, op, num, e};
        w20_o <= 32'h0;
        @(posedge clk_i);
        valid_o <= 1'b0;
        {type_o, chan_o, hdr_err_o, w16_o, w24_o, err_o} <= ~{t, c, he, op, num, e};
    endtask
    task automatic word(input logic [31:0] w);
        @(posedge clk_i);
        {dv_o, data_o} <= {1'b1, w};
        @(posedge clk_i);
        {dv_o, data_o} <= {1'b0, ~w};
    endtask
endmodule // sbxfer_mc
`default_nettype wire

// ===== dv/tb_top.sv
// self-checking bench for the sideband command handler
`default_nettype none
`include "sbxfer_regs.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_mismatch++; $display("[ERR] t=%0t got %h exp %h", $time, a, b); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rstn, wr, rd, cv, dv, xerr, rxb, pres, rdy, tv, rsp, tsd, busy, ready, act, held;
    logic [1:0] herr;
    logic [4:0] chan;
    logic [7:0] addr, ctype, rcmd;
    logic [15:0] alarm, warn, temp, rcode, rrsn;
    logic [31:0] wdata, rdata, w16, w20, w24, d, rw20, rw24, cap, rv, hnd, ctl;
    logic [31:0] blk[$], pend[$];
    int n_mismatch, check_count, seed, cyc, nxt;
    sbxfer_mc sbxfer_mc_i (.clk_i(clk), .valid_o(cv), .type_o(ctype), .chan_o(chan), .hdr_err_o(herr), .w16_o(w16),
        .w20_o(w20), .w24_o(w24), .err_o(xerr), .dv_o(dv), .data_o(d));
    sbxfer_top sbxfer_top_i (.REF_CLK_I(clk), .RESETN_I(rstn), .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WR_I(wr),
        .REG_RD_I(rd), .REG_RDATA_O(rdata), .CMD_VALID_I(cv), .CMD_TYPE_I(ctype), .CMD_CHAN_I(chan),
        .CMD_CSUM_ERR_I(herr[0]), .CMD_ID_ERR_I(herr[1]), .CMD_W16_I(w16), .CMD_W20_I(w20), .CMD_W24_I(w24),
        .DATA_VALID_I(dv), .DATA_I(d), .XFER_ERR_I(xerr), .RX_BUSY_I(rxb), .XCVR_PRESENT_I(pres),
        .XCVR_READY_I(rdy), .XCVR_TEMP_VALID_I(tv), .XCVR_ALARM_I(alarm), .XCVR_WARN_I(warn), .XCVR_TEMP_I(temp),
        .RSP_VALID_O(rsp), .RSP_CMD_O(rcmd), .RSP_CODE_O(rcode), .RSP_REASON_O(rrsn), .RSP_W20_O(rw20),
        .RSP_W24_O(rw24), .CAP_FLAGS_O(cap), .TSD_EN_O(tsd), .XFER_BUSY_O(busy), .BLOCK_READY_O(ready));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_mismatch++;
            complete_run();
        end
    end
    task automatic do_reset();
        @(posedge clk);
        rstn <= 1'b0;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        {act, held, hnd, ctl} = {2'b00, 32'h0, 32'h0000_690b};
        #1 `CHK({tsd, cap, busy, ready}, {1'b1, 32'h1 << `CAP_TSD_BIT, 2'b00})
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        {wr, addr, wdata} <= {1'b1, a, v};
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        {rd, addr} <= {1'b1, a};
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic rsp_chk(input logic [7:0] c, input logic [15:0] code, input logic [15:0] rsn);
        #1 `CHK({rsp, rcmd, rcode, rrsn}, {1'b1, c, code, rsn})
    endtask
    task automatic tsd_op(input logic [31:0] op);
        logic [15:0] code, rsn;
        {code, rsn} = {`RC_COMPLETED, `RR_NONE};
        if (!ctl[0]) code = `RC_UNSUPPORTED;
        else if (op > 2 || (op < 2 && (ctl[2] || !ctl[1]))) {code, rsn} = {`RC_FAILED, `RR_PARAM_INVALID};
        else if (op < 2) ctl[3] = op[0];
        sbxfer_mc_i.cmd(`CMD_TSD_CTRL, `PKG_CHAN_ID, op, 0, 2'b00, 1'b0);
        #1 `CHK({rsp, rcmd, rcode, cap}, {1'b1, 8'hcb, code, 32'(ctl[0]) << `CAP_TSD_BIT})
        if (ctl[0]) `CHK({rrsn, rw20, tsd}, {rsn, 16'h0, 6'h0, ctl[1], ctl[3], ctl[15:8], ctl[3]})
    endtask
    task automatic xf(input int op, input logic [31:0] num, input int nw, input logic e);
        logic [15:0] r;
        r = `RR_NONE;
        pend.delete();
        for (int i = 0; i < nw; i++) begin
            pend.push_back($random(seed));
            sbxfer_mc_i.word(pend[i]);
        end
        if (!(op inside {1, 2, 4, 5, 8})) r = `RR_PARAM_INVALID;
        else if (op == 8) act = 1'b0;
        else if (op[0]) begin
            if (rxb || act) r = `RR_ABORT;
            else if (held) r = `RR_NO_STORAGE;
            else if (num != hnd) r = `RR_BAD_HANDLE;
            else if (e) r = `RR_RETRY_CHUNK;
            else begin
                act = (op == 1);
                held = (op == 5);
                nxt = 2;
                blk = pend;
            end
        end else if (!act) r = `RR_ABORT;
        else if (num != nxt) {r, act} = {`RR_SEQ_ERR, 1'b0};
        else if (e) r = `RR_RETRY_CHUNK;
        else begin
            nxt++;
            act = (op == 2);
            held = (op == 4);
            blk = {blk, pend};
        end
        sbxfer_mc_i.cmd(`CMD_XFER_DATA, `PKG_CHAN_ID, op, num, 2'b00, e);
        rsp_chk(8'hcc, (r == 0) ? `RC_COMPLETED : `RC_FAILED, r);
        `CHK({busy, ready}, {act, held})
    endtask
    initial begin
        logic [23:0] seq[10] = '{24'h690b02, 24'h690b00, 24'h690b03, 24'h690b01, 24'h690bff, 24'h690f00,
            24'h690901, 24'h690a02, 24'h7f0b02, 24'h7f0b00};
        seed = 91674;
        {rstn, wr, rd, rxb, pres, rdy, tv, addr, wdata, alarm, warn, temp} = '0;
        do_reset();
        rreg(`REG_CTRL, rv);
        `CHK(rv, ctl)
        rreg(`REG_HANDLE, rv);
        `CHK(rv, 32'h0)
        rreg(8'h3c, rv);
        `CHK(rv, 32'h0)
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            {alarm, warn} <= $random(seed);
            temp <= 16'($random(seed));
            {pres, rdy, tv} <= (i < 3) ? ~(3'b001 << i) : 3'b111;
            sbxfer_mc_i.cmd(`CMD_XCVR_TEMP, 5'($random(seed)), 0, 0, 2'b00, 1'b0);
            rsp_chk(8'hca, (i < 3) ? `RC_FAILED : `RC_COMPLETED, (i < 3) ? `RR_INFO_UNAVAIL : `RR_NONE);
            if (i >= 3) `CHK({rw20, rw24}, {alarm, warn, temp, 16'h0})
        end
        for (int i = 0; i < 4; i++) begin
            sbxfer_mc_i.cmd((i[0] ^ i[1]) ? `CMD_XCVR_TEMP : `CMD_TSD_CTRL, i[1] ? 5'h0 : `PKG_CHAN_ID, 2, 0,
                2'(i + 1), 1'b0);
            #1 `CHK(rsp, 1'b0)
        end
        foreach (seq[i]) begin
            wreg(`REG_CTRL, {16'h0, seq[i][23:8]});
            ctl = {16'h0, seq[i][23:8]};
            tsd_op({24'h0, seq[i][7:0]});
        end
        hnd = $random(seed);
        wreg(`REG_HANDLE, hnd);
        xf(1, hnd, 3, 1'b0);
        xf(2, 2, 2, 1'b0);
        xf(4, 3, 1, 1'b0);
        rreg(`REG_STATUS, rv);
        `CHK({rv[21:16], rv[1:0]}, {6'(blk.size()), 2'b10})
        for (int i = 0; i < blk.size(); i++) begin
            wreg(`REG_RD_INDEX, i);
            rreg(`REG_RD_DATA, rv);
            `CHK(rv, blk[i])
        end
        xf(1, hnd, 1, 1'b0);
        wreg(`REG_STATUS, 32'h2);
        held = 1'b0;
        xf(1, hnd + 1, 1, 1'b0);
        xf(1, hnd, 1, 1'b0);
        xf(1, hnd, 0, 1'b0);
        xf(2, 3, 1, 1'b0);
        xf(2, 2, 1, 1'b0);
        xf(1, hnd, 2, 1'b0);
        xf(2, 2, 1, 1'b1);
        xf(2, 2, 1, 1'b0);
        xf(3, 3, 0, 1'b0);
        xf(8, 0, 0, 1'b0);
        rxb <= 1'b1;
        xf(1, hnd, 1, 1'b0);
        rxb <= 1'b0;
        xf(5, hnd, 1, 1'b0);
        wreg(`REG_STATUS, 32'h2);
        held = 1'b0;
        xf(1, hnd, 1, 1'b0);
        do_reset();
        xf(2, 2, 0, 1'b0);
        xf(1, 0, 1, 1'b0);
        complete_run();
    end
endmodule // tb_top
`default_nettype wire

// ===== hdl/sbxfer_pkg.sv
// types for the sideband thermal and data transfer command handler
`default_nettype none
package sbxfer_pkg;

    typedef struct packed {
        logic rsp_valid;
        logic [7:0] rsp_cmd;
        logic [15:0] rsp_code;
        logic [15:0] rsp_reason;
        logic [31:0] rsp_w20;
        logic [31:0] rsp_w24;
        logic tsd_present;
        logic ed_sup;
        logic cfg_ro;
        logic tsd_en;
        logic [7:0] sd_temp;
        logic [31:0] handle;
        logic active;
        logic block_ready;
        logic [31:0] exp_chunk;
        logic [31:0] offset;
        logic [5:0] base;
        logic [5:0] wr_ptr;
        logic ovf;
        logic [5:0] blk_words;
        logic [4:0] rd_idx;
        logic [31:0] rdata;
    } state_t;

endpackage : sbxfer_pkg
`default_nettype wire

// ===== hdl/sbxfer_regs.svh
// constants for the sideband thermal and data transfer command handler
`ifndef SBXFER_REGS_SVH
`define SBXFER_REGS_SVH

// command codes, response code is command code with bit 7 set
`define CMD_XCVR_TEMP 8'h4a
`define CMD_TSD_CTRL 8'h4b
`define CMD_XFER_DATA 8'h4c
`define RSP_FLAG 8'h80
`define PKG_CHAN_ID 5'h1f

// thermal shutdown operation field
`define TSD_OP_DISABLE 8'h00
`define TSD_OP_ENABLE 8'h01
`define TSD_OP_QUERY 8'h02

// transfer opcode field
`define XOP_INIT 8'h01
`define XOP_MID 8'h02
`define XOP_FINAL 8'h04
`define XOP_INIT_FINAL 8'h05
`define XOP_ABORT 8'h08

// response and reason codes
`define RC_COMPLETED 16'h0000
`define RC_FAILED 16'h0001
`define RC_UNSUPPORTED 16'h0003
`define RR_NONE 16'h0000
`define RR_PARAM_INVALID 16'h0002
`define RR_INFO_UNAVAIL 16'h0009
`define RR_RETRY_CHUNK 16'h4c10
`define RR_ABORT 16'h4c01
`define RR_BAD_HANDLE 16'h4c02
`define RR_SEQ_ERR 16'h4c03
`define RR_NO_STORAGE 16'h4c04

// first chunk number after the initial chunk
`define FIRST_MID_CHUNK 32'h0000_0002
`define CAP_TSD_BIT 7

// software register offsets
`define REG_CTRL 8'h00
`define REG_HANDLE 8'h04
`define REG_STATUS 8'h08
`define REG_RD_INDEX 8'h10
`define REG_RD_DATA 8'h14

// control register fields and reset values
`define CTRL_PRESENT_BIT 0
`define CTRL_ED_SUP_BIT 1
`define CTRL_RO_BIT 2
`define CTRL_EN_BIT 3
`define STAT_CLR_READY_BIT 1
`define SD_TEMP_RESET 8'h69
`define HANDLE_RESET 32'h0000_0000

// block store
`define BLK_DEPTH 32
`define BLK_FULL 6'h20

`endif

// ===== hdl/sbxfer_top.sv
// sideband command handler: transceiver temperature, thermal shutdown control, data transfer to controller
//
// Summary of operation
// - always answer temperature query unless header error
// - 16-bit values as contiguous half-word fields
// - transceiver temperature data passed unchanged
// - every channel answers its temperature query
// - info-unavailable when transceiver absent or unready
// - alarm/warning in word 20, temperature high word 24
// - capability bit 7 shows shutdown feature
// - shutdown control addressed to package id 0x1F
// - operation 0 disable, 1 enable, 2 query
// - answer shutdown control only when addressed to package id 0x1F, unless header error
// - status shows enablement after command executes
// - read-only config rejects enable/disable, param invalid
// - shutdown temperature low byte, status above it
// - status bit0 enabled, bit1 enable/disable supported
// - unsupported data handle terminates the transfer
// - retransmission only of the active chunk
// - block processed only after all chunks received
// - reset or out-of-order chunk aborts transfer
// - only one active transfer sequence at once
// - opcodes 1,2,4,5 and 8 abort, others reserved
// - initial carries handle, later chunks count from 2
// - chunk number gap gives 0x4C03 and aborts
//
// The register offsets and the plain strobed port were decided locally.
`default_nettype none
`include "sbxfer_regs.svh"

module sbxfer_top (
    input wire logic REF_CLK_I, // 50 MHz clock
    input wire logic RESETN_I, // asynchronous reset, active low
    input wire logic [7:0] REG_ADDR_I, // register byte address
    input wire logic [31:0] REG_WDATA_I, // register write data
    input wire logic REG_WR_I, // register write strobe
    input wire logic REG_RD_I, // register read strobe
    output logic [31:0] REG_RDATA_O, // read data, cycle after strobe
    input wire logic CMD_VALID_I, // one-cycle command strobe
    input wire logic [7:0] CMD_TYPE_I, // command code
    input wire logic [4:0] CMD_CHAN_I, // internal channel id
    input wire logic CMD_CSUM_ERR_I, // checksum error on this command
    input wire logic CMD_ID_ERR_I, // identifier mismatch on this command
    input wire logic [31:0] CMD_W16_I, // payload bytes 16..19
    input wire logic [31:0] CMD_W20_I, // payload bytes 20..23
    input wire logic [31:0] CMD_W24_I, // payload bytes 24..27
    input wire logic DATA_VALID_I, // chunk data word strobe
    input wire logic [31:0] DATA_I, // chunk data word
    input wire logic XFER_ERR_I, // transfer error seen on current chunk
    input wire logic RX_BUSY_I, // receive-direction sequence active
    input wire logic XCVR_PRESENT_I, // transceiver fitted
    input wire logic XCVR_READY_I, // transceiver powered up
    input wire logic XCVR_TEMP_VALID_I, // transceiver gives temperature data
    input wire logic [15:0] XCVR_ALARM_I, // high alarm threshold
    input wire logic [15:0] XCVR_WARN_I, // high warning threshold
    input wire logic [15:0] XCVR_TEMP_I, // module temperature
    output logic RSP_VALID_O, // one-cycle response strobe
    output logic [7:0] RSP_CMD_O, // response code byte
    output logic [15:0] RSP_CODE_O, // response code
    output logic [15:0] RSP_REASON_O, // reason code
    output logic [31:0] RSP_W20_O, // response bytes 20..23
    output logic [31:0] RSP_W24_O, // response bytes 24..27
    output logic [31:0] CAP_FLAGS_O, // capability flags contribution
    output logic TSD_EN_O, // thermal self-shutdown enabled
    output logic XFER_BUSY_O, // transmit sequence active
    output logic BLOCK_READY_O // full block held, ready to process
);
    import sbxfer_pkg::*;

    state_t q, d;
    logic [31:0] mem [`BLK_DEPTH];
    logic hdr_ok, xcvr_ok, stage_wr;
    logic [7:0] op;

    assign hdr_ok = CMD_VALID_I && !CMD_CSUM_ERR_I && !CMD_ID_ERR_I;
    assign xcvr_ok = XCVR_PRESENT_I && XCVR_READY_I && XCVR_TEMP_VALID_I;
    assign op = CMD_W16_I[7:0];
    // staging is frozen while a finished block waits for software
    assign stage_wr = DATA_VALID_I && !q.block_ready && !q.ovf && (q.wr_ptr != `BLK_FULL);

    always_comb begin
        d = q;
        d.rsp_valid = 1'b0;
        d.rdata = 32'h0;

        // register port
        if (REG_WR_I) begin
            unique case (REG_ADDR_I)
                `REG_CTRL: begin
                    d.tsd_present = REG_WDATA_I[`CTRL_PRESENT_BIT];
                    d.ed_sup = REG_WDATA_I[`CTRL_ED_SUP_BIT];
                    d.cfg_ro = REG_WDATA_I[`CTRL_RO_BIT];
                    d.tsd_en = REG_WDATA_I[`CTRL_EN_BIT];
                    d.sd_temp = REG_WDATA_I[15:8];
                end
                `REG_HANDLE: d.handle = REG_WDATA_I;
                `REG_STATUS: begin
                    if (REG_WDATA_I[`STAT_CLR_READY_BIT] && q.block_ready) begin
                        d.block_ready = 1'b0;
                        d.base = 6'h0;
                        d.wr_ptr = 6'h0;
                        d.blk_words = 6'h0;
                    end
                end
                `REG_RD_INDEX: d.rd_idx = REG_WDATA_I[4:0];
                default: ;
            endcase
        end
        if (REG_RD_I) begin
            unique case (REG_ADDR_I)
                `REG_CTRL: d.rdata = {16'h0, q.sd_temp, 4'h0, q.tsd_en, q.cfg_ro, q.ed_sup, q.tsd_present};
                `REG_HANDLE: d.rdata = q.handle;
                `REG_STATUS: d.rdata = {10'h0, q.blk_words, q.exp_chunk[7:0], 5'h0, q.ovf, q.block_ready, q.active};
                `REG_RD_INDEX: d.rdata = {27'h0, q.rd_idx};
                `REG_RD_DATA: d.rdata = mem[q.rd_idx];
                default: d.rdata = 32'h0;
            endcase
        end

        // chunk data staging
        if (DATA_VALID_I && !q.block_ready) begin
            if (stage_wr) begin
                d.wr_ptr = q.wr_ptr + 6'h1;
            end else begin
                d.ovf = 1'b1;
            end
        end

        if (hdr_ok) begin
            d.rsp_cmd = CMD_TYPE_I | `RSP_FLAG;
            d.rsp_code = `RC_COMPLETED;
            d.rsp_reason = `RR_NONE;
            d.rsp_w20 = 32'h0;
            d.rsp_w24 = 32'h0;
            unique case (CMD_TYPE_I)
                `CMD_XCVR_TEMP: begin
                    d.rsp_valid = 1'b1;
                    if (xcvr_ok) begin
                        d.rsp_w20 = {XCVR_ALARM_I, XCVR_WARN_I};
                        d.rsp_w24 = {XCVR_TEMP_I, 16'h0};
                    end else begin
                        d.rsp_code = `RC_FAILED;
                        d.rsp_reason = `RR_INFO_UNAVAIL;
                    end
                end
                `CMD_TSD_CTRL: begin
                    d.rsp_valid = (CMD_CHAN_I == `PKG_CHAN_ID);
                    if (!q.tsd_present) begin
                        d.rsp_code = `RC_UNSUPPORTED;
                    end else begin
                        unique case (op)
                            `TSD_OP_QUERY: ;
                            `TSD_OP_DISABLE, `TSD_OP_ENABLE: begin
                                if (q.cfg_ro || !q.ed_sup) begin
                                    d.rsp_code = `RC_FAILED;
                                    d.rsp_reason = `RR_PARAM_INVALID;
                                end else if (d.rsp_valid) begin
                                    d.tsd_en = op[0];
                                end
                            end
                            default: begin
                                d.rsp_code = `RC_FAILED;
                                d.rsp_reason = `RR_PARAM_INVALID;
                            end
                        endcase
                        // status reflects state after this command
                        d.rsp_w20 = {16'h0, 6'h0, q.ed_sup, d.tsd_en, q.sd_temp};
                    end
                end
                `CMD_XFER_DATA: begin
                    d.rsp_valid = (CMD_CHAN_I == `PKG_CHAN_ID);
                    if (d.rsp_valid) begin
                        d.rsp_code = `RC_FAILED;
                        unique case (op)
                            `XOP_INIT, `XOP_INIT_FINAL: begin
                                if (q.active || RX_BUSY_I) begin
                                    d.rsp_reason = `RR_ABORT;
                                    if (!q.active) d.wr_ptr = q.base;
                                end else if (q.block_ready) begin
                                    d.rsp_reason = `RR_NO_STORAGE;
                                end else if (CMD_W24_I != q.handle) begin
                                    d.rsp_reason = `RR_BAD_HANDLE;
                                    d.wr_ptr = q.base;
                                end else if (q.ovf) begin
                                    d.rsp_reason = `RR_NO_STORAGE;
                                    d.wr_ptr = q.base;
                                end else if (XFER_ERR_I) begin
                                    d.rsp_reason = `RR_RETRY_CHUNK;
                                    d.wr_ptr = q.base;
                                end else begin
                                    d.rsp_code = `RC_COMPLETED;
                                    d.base = q.wr_ptr;
                                    d.offset = CMD_W20_I;
                                    d.exp_chunk = `FIRST_MID_CHUNK;
                                    d.active = (op == `XOP_INIT);
                                    d.block_ready = (op == `XOP_INIT_FINAL);
                                    d.blk_words = q.wr_ptr;
                                end
                            end
                            `XOP_MID, `XOP_FINAL: begin
                                if (!q.active) begin
                                    d.rsp_reason = `RR_ABORT;
                                    d.wr_ptr = q.base;
                                end else if (CMD_W24_I != q.exp_chunk) begin
                                    d.rsp_reason = `RR_SEQ_ERR;
                                    d.active = 1'b0;
                                    d.base = 6'h0;
                                    d.wr_ptr = 6'h0;
                                end else if (q.ovf) begin
                                    d.rsp_reason = `RR_NO_STORAGE;
                                    d.active = 1'b0;
                                    d.base = 6'h0;
                                    d.wr_ptr = 6'h0;
                                end else if (XFER_ERR_I) begin
                                    // only the active chunk is discarded and asked for again
                                    d.rsp_reason = `RR_RETRY_CHUNK;
                                    d.wr_ptr = q.base;
                                end else begin
                                    d.rsp_code = `RC_COMPLETED;
                                    d.base = q.wr_ptr;
                                    d.exp_chunk = q.exp_chunk + 32'h1;
                                    if (op == `XOP_FINAL) begin
                                        d.active = 1'b0;
                                        d.block_ready = 1'b1;
                                        d.blk_words = q.wr_ptr;
                                    end
                                end
                            end
                            `XOP_ABORT: begin
                                d.rsp_code = `RC_COMPLETED;
                                if (q.active) begin
                                    d.active = 1'b0;
                                    d.base = 6'h0;
                                    d.wr_ptr = 6'h0;
                                end else begin
                                    d.wr_ptr = q.base;
                                end
                            end
                            default: begin
                                d.rsp_reason = `RR_PARAM_INVALID;
                                d.wr_ptr = q.base;
                            end
                        endcase
                        d.ovf = 1'b0;
                    end
                end
                default: ;
            endcase
            // the last response's fields stand until another response goes out
            if (!d.rsp_valid) begin
                d.rsp_cmd = q.rsp_cmd;
                d.rsp_code = q.rsp_code;
                d.rsp_reason = q.rsp_reason;
                d.rsp_w20 = q.rsp_w20;
                d.rsp_w24 = q.rsp_w24;
            end
        end
    end

    // reset drops any transfer in progress
    always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            q <= '0;
            q.tsd_present <= 1'b1;
            q.ed_sup <= 1'b1;
            q.tsd_en <= 1'b1;
            q.sd_temp <= `SD_TEMP_RESET;
            q.handle <= `HANDLE_RESET;
        end else begin
            q <= d;
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (stage_wr) begin
            mem[q.wr_ptr[4:0]] <= DATA_I;
        end
    end

    assign REG_RDATA_O = q.rdata;
    assign RSP_VALID_O = q.rsp_valid;
    assign RSP_CMD_O = q.rsp_cmd;
    assign RSP_CODE_O = q.rsp_code;
    assign RSP_REASON_O = q.rsp_reason;
    assign RSP_W20_O = q.rsp_w20;
    assign RSP_W24_O = q.rsp_w24;
    assign CAP_FLAGS_O = {24'h0, q.tsd_present, 7'h0};
    assign TSD_EN_O = q.tsd_en;
    assign XFER_BUSY_O = q.active;
    assign BLOCK_READY_O = q.block_ready;

    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (!RESETN_I);

    temp_answer_a: assert property (
        hdr_ok && CMD_TYPE_I == `CMD_XCVR_TEMP |=> RSP_VALID_O && RSP_CMD_O == 8'hca)
        else $error("temperature query not answered");

    temp_fields_a: assert property (
        hdr_ok && CMD_TYPE_I == `CMD_XCVR_TEMP && xcvr_ok
        |=> RSP_W20_O == {$past(XCVR_ALARM_I), $past(XCVR_WARN_I)} && RSP_W24_O[31:16] == $past(XCVR_TEMP_I)
            && RSP_W24_O[15:0] == 16'h0)
        else $error("temperature fields misplaced");

    temp_unavail_a: assert property (
        hdr_ok && CMD_TYPE_I == `CMD_XCVR_TEMP && !xcvr_ok |=> RSP_REASON_O == `RR_INFO_UNAVAIL)
        else $error("missing info-unavailable reason");

    tsd_pkg_only_a: assert property (
        hdr_ok && CMD_TYPE_I == `CMD_TSD_CTRL && CMD_CHAN_I != `PKG_CHAN_ID |=> !RSP_VALID_O)
        else $error("shutdown control answered on a channel id");

    tsd_ro_reject_a: assert property (
        hdr_ok && CMD_TYPE_I == `CMD_TSD_CTRL && CMD_CHAN_I == `PKG_CHAN_ID && q.tsd_present && q.cfg_ro
        && op <= `TSD_OP_ENABLE |=> RSP_REASON_O == `RR_PARAM_INVALID && TSD_EN_O == $past(TSD_EN_O))
        else $error("read-only enable or disable not rejected");

    tsd_status_a: assert property (
        RSP_VALID_O && RSP_CMD_O == 8'hcb && RSP_CODE_O != `RC_UNSUPPORTED
        |-> RSP_W20_O[8] == TSD_EN_O && RSP_W20_O[9] == q.ed_sup && RSP_W20_O[31:10] == 22'h0)
        else $error("shutdown status byte wrong");

    seq_error_a: assert property (
        hdr_ok && CMD_TYPE_I == `CMD_XFER_DATA && CMD_CHAN_I == `PKG_CHAN_ID && q.active
        && (op == `XOP_MID || op == `XOP_FINAL) && CMD_W24_I != q.exp_chunk
        |=> RSP_REASON_O == `RR_SEQ_ERR && !XFER_BUSY_O ##1 !XFER_BUSY_O)
        else $error("out-of-order chunk not aborted");

    one_sequence_a: assert property (
        hdr_ok && CMD_TYPE_I == `CMD_XFER_DATA && CMD_CHAN_I == `PKG_CHAN_ID && op == `XOP_INIT && RX_BUSY_I
        && !q.active |=> RSP_CODE_O == `RC_FAILED && !XFER_BUSY_O)
        else $error("second sequence started");

    block_hold_a: assert property (
        $rose(BLOCK_READY_O) |-> $past(q.active) || $past(op) == `XOP_INIT_FINAL)
        else $error("block ready without completed sequence");

endmodule // sbxfer_top
`default_nettype wire
